// >>> design/itd_pkg.sv
package itd_pkg;
    localparam int WORD_W       = 14;
    localparam int DATA_W       = 8;
    localparam int ADDR_W       = 7;
    localparam int BIT_W        = 3;
    localparam int LIT_W        = 8;
    localparam int JUMP_W       = 11;
    localparam int BRANCH_W     = 9;
    localparam int MODE_W       = 2;
    localparam int OSC_PER_CYC  = 4;
    localparam int QPH_W        = 2;
    localparam int OSC_NS       = 10;
    // Instruction cycle length in ns, derived from oscillator period
    localparam int INSN_NS      = OSC_NS * OSC_PER_CYC;
    // Field positions
    localparam int DEST_POS     = 7;
    localparam int BIT_POS      = 7;
    localparam int PTR_POS      = 2;
    localparam int MODE_POS     = 0;
    localparam logic [WORD_W-1:0] NOP_WORD = 14'h0000;

    typedef enum logic [4:0] {
        ITD_OP_NOP, ITD_OP_BYTE_ALU, ITD_OP_ADD_WITH_CARRY, ITD_OP_SUB_WITH_BORROW,
        ITD_OP_CLEAR_F, ITD_OP_CLEAR_W, ITD_OP_MOVE_W_TO_F, ITD_OP_SKIP_DEC, ITD_OP_SKIP_INC,
        ITD_OP_BIT_CLEAR, ITD_OP_BIT_SET, ITD_OP_SKIP_IF_CLEAR, ITD_OP_SKIP_IF_SET,
        ITD_OP_LITERAL_ALU, ITD_OP_LOAD_PC_HIGH, ITD_OP_LOAD_BANK, ITD_OP_CALL, ITD_OP_CALL_BY_W,
        ITD_OP_RETURN, ITD_OP_RETURN_LIT, ITD_OP_INT_RETURN, ITD_OP_JUMP, ITD_OP_REL_BRANCH,
        ITD_OP_BRANCH_BY_W, ITD_OP_INDIRECT_MOVE, ITD_OP_OTHER
    } itd_op_t;

    typedef enum logic [1:0] {
        ITD_PRE_INC  = 2'h0,
        ITD_PRE_DEC  = 2'h1,
        ITD_POST_INC = 2'h2,
        ITD_POST_DEC = 2'h3
    } itd_ptr_mode_t;
endpackage

// >>> design/itd_dec_if.sv
`timescale 1ns/1ns
interface itd_dec_if;
    logic [itd_pkg::WORD_W-1:0] word;
    itd_pkg::itd_op_t           op;
    logic                       uses_file;
    logic                       two_cycle;
    logic                       cond_skip;
    logic                       indirect;
    logic                       dest_file;
    logic [itd_pkg::ADDR_W-1:0] faddr;
    logic [itd_pkg::BIT_W-1:0]  bitsel;
    logic [itd_pkg::LIT_W-1:0]  literal;
    logic                       ptr_sel;
    itd_pkg::itd_ptr_mode_t     ptr_mode;
    modport core (output word, input op, uses_file, two_cycle, cond_skip, indirect, dest_file,
                  faddr, bitsel, literal, ptr_sel, ptr_mode);
    modport dec  (input word, output op, uses_file, two_cycle, cond_skip, indirect, dest_file,
                  faddr, bitsel, literal, ptr_sel, ptr_mode);
endinterface

// >>> design/itd_field_dec.sv
`timescale 1ns/1ns
module itd_field_dec (
    itd_dec_if.dec d
);
    logic [13:0] w;
    assign w = d.word;

    always_comb begin
        d.op        = itd_pkg::ITD_OP_OTHER;
        d.uses_file = 1'b0;
        d.two_cycle = 1'b0;
        d.cond_skip = 1'b0;
        d.indirect  = 1'b0;
        // Don't-care bits are never looked at, so x=0 and x=1 decode alike
        // Patterns overlap, so the first match must win
        priority casez (w)
            14'b11_1101_????_????: begin
                d.op = itd_pkg::ITD_OP_ADD_WITH_CARRY;
            end
            14'b11_1011_????_????: begin
                d.op = itd_pkg::ITD_OP_SUB_WITH_BORROW;
            end
            14'b11_0001_1???_????: begin
                d.op = itd_pkg::ITD_OP_LOAD_PC_HIGH;
            end
            14'b00_0001_0000_00??: d.op = itd_pkg::ITD_OP_CLEAR_W;
            14'b00_0001_1???_????: d.op = itd_pkg::ITD_OP_CLEAR_F;
            14'b00_0000_1???_????: d.op = itd_pkg::ITD_OP_MOVE_W_TO_F;
            14'b00_0000_0000_0000: d.op = itd_pkg::ITD_OP_NOP;
            14'b00_0000_0000_1000: d.op = itd_pkg::ITD_OP_RETURN;
            14'b00_0000_0000_1001: d.op = itd_pkg::ITD_OP_INT_RETURN;
            14'b00_0000_0000_1010: d.op = itd_pkg::ITD_OP_CALL_BY_W;
            14'b00_0000_0000_1011: d.op = itd_pkg::ITD_OP_BRANCH_BY_W;
            14'b00_0000_0001_0???: d.op = itd_pkg::ITD_OP_INDIRECT_MOVE;
            14'b00_0000_001?_????: d.op = itd_pkg::ITD_OP_LOAD_BANK;
            14'b00_1011_????_????: d.op = itd_pkg::ITD_OP_SKIP_DEC;
            14'b00_1111_????_????: d.op = itd_pkg::ITD_OP_SKIP_INC;
            14'b00_????_????_????: d.op = itd_pkg::ITD_OP_BYTE_ALU;
            14'b01_00??_????_????: d.op = itd_pkg::ITD_OP_BIT_CLEAR;
            14'b01_01??_????_????: d.op = itd_pkg::ITD_OP_BIT_SET;
            14'b01_10??_????_????: d.op = itd_pkg::ITD_OP_SKIP_IF_CLEAR;
            14'b01_11??_????_????: d.op = itd_pkg::ITD_OP_SKIP_IF_SET;
            14'b10_0???_????_????: d.op = itd_pkg::ITD_OP_CALL;
            14'b10_1???_????_????: d.op = itd_pkg::ITD_OP_JUMP;
            14'b11_001?_????_????: d.op = itd_pkg::ITD_OP_REL_BRANCH;
            14'b11_0100_????_????: d.op = itd_pkg::ITD_OP_RETURN_LIT;
            14'b11_01??_????_????: d.op = itd_pkg::ITD_OP_BYTE_ALU;
            default:               d.op = itd_pkg::ITD_OP_LITERAL_ALU;
        endcase
        unique case (d.op)
            itd_pkg::ITD_OP_BYTE_ALU, itd_pkg::ITD_OP_ADD_WITH_CARRY, itd_pkg::ITD_OP_SUB_WITH_BORROW,
            itd_pkg::ITD_OP_CLEAR_F, itd_pkg::ITD_OP_MOVE_W_TO_F, itd_pkg::ITD_OP_BIT_CLEAR,
            itd_pkg::ITD_OP_BIT_SET: d.uses_file = 1'b1;
            itd_pkg::ITD_OP_SKIP_DEC, itd_pkg::ITD_OP_SKIP_INC, itd_pkg::ITD_OP_SKIP_IF_CLEAR,
            itd_pkg::ITD_OP_SKIP_IF_SET: begin
                d.uses_file = 1'b1;
                d.cond_skip = 1'b1;
            end
            itd_pkg::ITD_OP_CALL, itd_pkg::ITD_OP_CALL_BY_W: d.two_cycle = 1'b1;
            itd_pkg::ITD_OP_RETURN, itd_pkg::ITD_OP_RETURN_LIT,
            itd_pkg::ITD_OP_INT_RETURN: d.two_cycle = 1'b1;
            itd_pkg::ITD_OP_JUMP, itd_pkg::ITD_OP_REL_BRANCH,
            itd_pkg::ITD_OP_BRANCH_BY_W: d.two_cycle = 1'b1;
            itd_pkg::ITD_OP_INDIRECT_MOVE: d.indirect = 1'b1;
            default: begin
            end
        endcase
    end

    // Operand fields
    assign d.dest_file = w[itd_pkg::DEST_POS];
    assign d.faddr     = w[itd_pkg::ADDR_W-1:0];
    assign d.bitsel    = w[itd_pkg::BIT_POS +: itd_pkg::BIT_W];
    assign d.literal   = w[itd_pkg::LIT_W-1:0];
    assign d.ptr_sel   = w[itd_pkg::PTR_POS];
    assign d.ptr_mode  = itd_pkg::itd_ptr_mode_t'(w[itd_pkg::MODE_POS +: itd_pkg::MODE_W]);
endmodule

// >>> design/itd_core.sv
// Operation
// - Whole 14-bit word carries opcode and operands
// - Default instructions take one instruction cycle
// - Both call forms take two cycles
// - All return forms take two cycles
// - Jumps, branches, taken skips take two cycles
// - Indirect access to program memory adds cycle
// - Instruction cycle equals four oscillator clocks
// - File operands read, modify, write, except bit-test skips, which only read
// - Destination bit picks working or file
// - File address spans 0x00 to 0x7F
// - Bit field picks one of eight bits
// - Pointer field selects pointer zero or one
// - Don't-care bits never change decode
// - Two-bit mode picks pre/post increment/decrement
// - Literal operand comes from literal field
// - Add-with-carry decode and flag updates
// - Subtract-with-borrow decode and flag updates
// - Decrement skip: one cycle, two when zero
// - Load pc high literal, one cycle
`timescale 1ns/1ns
module itd_core (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       nrst,
    input  wire logic                       clk_en,
    // Instruction from program memory
    input  wire logic [itd_pkg::WORD_W-1:0] insn_word,
    // Data path context
    input  wire logic [itd_pkg::DATA_W-1:0] file_rdata,
    input  wire logic                       ptr_in_prog_mem,
    input  wire logic                       carry_in,
    input  wire logic                       skip_cond,
    // Fetch and file port
    output logic                            fetch_req,
    output logic                            file_rd,
    output logic                            file_wr,
    output logic [itd_pkg::ADDR_W-1:0]      file_addr,
    output logic [itd_pkg::DATA_W-1:0]      file_wdata,
    // Decoded results
    output logic                            w_wr,
    output logic [itd_pkg::DATA_W-1:0]      result,
    output logic [2:0]                      flags,
    output logic [itd_pkg::BIT_W-1:0]       bit_sel,
    output logic                            ptr_sel,
    output logic [itd_pkg::MODE_W-1:0]      ptr_mode,
    output logic [itd_pkg::LIT_W-1:0]       literal,
    output logic                            cycle_end,
    output logic                            flushed
);
    typedef enum logic [1:0] {
        ITD_Q1 = 2'b00,
        ITD_Q2 = 2'b01,
        ITD_Q3 = 2'b11,
        ITD_Q4 = 2'b10
    } itd_q_t;

    itd_dec_if dif ();
    itd_field_dec u_dec (.d(dif));

    itd_q_t                       q_r, q_nxt;
    logic [itd_pkg::WORD_W-1:0]   ir_r, ir_nxt;
    logic [1:0]                   extra_r, extra_nxt;
    logic                         flush_r, flush_nxt;
    logic [itd_pkg::DATA_W-1:0]   val_r, val_nxt;
    logic                         fetch_req_r, file_rd_r, file_wr_r, w_wr_r, cyc_end_r, flushed_r;
    logic                         fetch_req_nxt, file_rd_nxt, file_wr_nxt, w_wr_nxt, cyc_end_nxt, flushed_nxt;
    logic [2:0]                   flags_r, flags_nxt;
    logic [itd_pkg::DATA_W-1:0]   alu_res;
    logic [2:0]                   alu_flags;
    logic                         skip_taken;
    logic                         to_w_only;

    // Flags are {carry, digit carry, zero}
    function automatic logic [11:0] add_flags(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        return {s[7:0], 1'b0, s[8], h[4], s[7:0] == 8'h00};
    endfunction

    assign dif.word = ir_r;

    // Literal-class results go to the working register only
    assign to_w_only = (dif.op == itd_pkg::ITD_OP_LITERAL_ALU) | (dif.op == itd_pkg::ITD_OP_RETURN_LIT) |
                       (dif.op == itd_pkg::ITD_OP_CLEAR_W);

    always_comb begin
        logic [11:0] r;
        r         = 12'h000;
        alu_res   = val_r;
        alu_flags = flags_r;
        unique case (dif.op)
            itd_pkg::ITD_OP_ADD_WITH_CARRY: begin
                r         = add_flags(file_rdata, val_r, carry_in);
                alu_res   = r[11:4];
                alu_flags = r[2:0];
            end
            itd_pkg::ITD_OP_SUB_WITH_BORROW: begin
                r         = add_flags(file_rdata, ~val_r, carry_in);
                alu_res   = r[11:4];
                alu_flags = r[2:0];
            end
            itd_pkg::ITD_OP_SKIP_DEC: alu_res = file_rdata - 8'h01;
            itd_pkg::ITD_OP_SKIP_INC: alu_res = file_rdata + 8'h01;
            itd_pkg::ITD_OP_BIT_CLEAR: alu_res = file_rdata & ~(8'h01 << dif.bitsel);
            itd_pkg::ITD_OP_BIT_SET: alu_res = file_rdata | (8'h01 << dif.bitsel);
            itd_pkg::ITD_OP_CLEAR_F, itd_pkg::ITD_OP_CLEAR_W: alu_res = 8'h00;
            itd_pkg::ITD_OP_MOVE_W_TO_F: alu_res = val_r;
            itd_pkg::ITD_OP_LITERAL_ALU, itd_pkg::ITD_OP_LOAD_PC_HIGH,
            itd_pkg::ITD_OP_RETURN_LIT: alu_res = dif.literal;
            default: alu_res = file_rdata;
        endcase
    end

    // Skip decision: zero result for count skips, bit test otherwise
    always_comb begin
        unique case (dif.op)
            itd_pkg::ITD_OP_SKIP_DEC, itd_pkg::ITD_OP_SKIP_INC: skip_taken = (alu_res == 8'h00);
            itd_pkg::ITD_OP_SKIP_IF_CLEAR: skip_taken = ~file_rdata[dif.bitsel];
            itd_pkg::ITD_OP_SKIP_IF_SET: skip_taken = file_rdata[dif.bitsel];
            default: skip_taken = skip_cond & 1'b0;
        endcase
    end

    // Four oscillator clocks per instruction cycle: Q1 decode, Q2 read, Q3 modify, Q4 write
    always_comb begin
        q_nxt         = q_r;
        ir_nxt        = ir_r;
        extra_nxt     = extra_r;
        flush_nxt     = flush_r;
        val_nxt       = val_r;
        flags_nxt     = flags_r;
        fetch_req_nxt = 1'b0;
        file_rd_nxt   = 1'b0;
        file_wr_nxt   = 1'b0;
        w_wr_nxt      = 1'b0;
        cyc_end_nxt   = 1'b0;
        flushed_nxt   = flushed_r;
        unique case (q_r)
            ITD_Q1: begin
                q_nxt = ITD_Q2;
                if (extra_r == 2'd0) begin
                    file_rd_nxt = dif.uses_file;
                end
            end
            ITD_Q2: q_nxt = ITD_Q3;
            ITD_Q3: q_nxt = ITD_Q4;
            ITD_Q4: begin
                q_nxt       = ITD_Q1;
                cyc_end_nxt = 1'b1;
                if (extra_r != 2'd0) begin
                    extra_nxt = extra_r - 2'd1;
                    if (extra_r == 2'd1) begin
                        // Extra slot over: the next word is taken now
                        fetch_req_nxt = 1'b1;
                        ir_nxt        = insn_word;
                        flush_nxt     = 1'b0;
                        flushed_nxt   = 1'b0;
                    end
                end else begin
                    if (!flush_r && (dif.uses_file || to_w_only) && dif.op != itd_pkg::ITD_OP_SKIP_IF_CLEAR &&
                        dif.op != itd_pkg::ITD_OP_SKIP_IF_SET) begin
                        file_wr_nxt = dif.uses_file & (dif.dest_file | (dif.op == itd_pkg::ITD_OP_CLEAR_F) |
                                      (dif.op == itd_pkg::ITD_OP_MOVE_W_TO_F) |
                                      (dif.op == itd_pkg::ITD_OP_BIT_CLEAR) |
                                      (dif.op == itd_pkg::ITD_OP_BIT_SET));
                        w_wr_nxt    = ~file_wr_nxt;
                        val_nxt     = alu_res;
                        flags_nxt   = alu_flags;
                    end
                    // Extra cycle count beyond the default single cycle
                    extra_nxt = {1'b0, dif.two_cycle | (dif.cond_skip & skip_taken)} +
                                {1'b0, dif.indirect & ptr_in_prog_mem};
                    // The prefetched word is replaced by a no-op
                    flush_nxt   = dif.two_cycle | (dif.cond_skip & skip_taken);
                    flushed_nxt = flush_nxt;
                    // A taken skip consumes the word it drops; a jump refuses it, its target comes next
                    fetch_req_nxt = (extra_nxt == 2'd0) || (dif.cond_skip && skip_taken);
                    // An indirect stall keeps its word so the operand fields stand
                    ir_nxt = flush_nxt ? itd_pkg::NOP_WORD : ((extra_nxt == 2'd0) ? insn_word : ir_r);
                end
            end
            default: q_nxt = ITD_Q1;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_r         <= ITD_Q1;
            ir_r        <= itd_pkg::NOP_WORD;
            extra_r     <= 2'd0;
            flush_r     <= 1'b0;
            val_r       <= 8'h00;
            flags_r     <= 3'h0;
            fetch_req_r <= 1'b0;
            file_rd_r   <= 1'b0;
            file_wr_r   <= 1'b0;
            w_wr_r      <= 1'b0;
            cyc_end_r   <= 1'b0;
            flushed_r   <= 1'b0;
        end else if (clk_en) begin
            q_r         <= q_nxt;
            ir_r        <= ir_nxt;
            extra_r     <= extra_nxt;
            flush_r     <= flush_nxt;
            val_r       <= val_nxt;
            flags_r     <= flags_nxt;
            fetch_req_r <= fetch_req_nxt;
            file_rd_r   <= file_rd_nxt;
            file_wr_r   <= file_wr_nxt;
            w_wr_r      <= w_wr_nxt;
            cyc_end_r   <= cyc_end_nxt;
            flushed_r   <= flushed_nxt;
        end
    end

    // Operand fields are registered copies so that outputs come from flip-flops
    logic [itd_pkg::ADDR_W-1:0] addr_r;
    logic [itd_pkg::BIT_W-1:0]  bit_r;
    logic                       ps_r;
    logic [itd_pkg::MODE_W-1:0] pm_r;
    logic [itd_pkg::LIT_W-1:0]  lit_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            addr_r <= 7'h00;
            bit_r  <= 3'h0;
            ps_r   <= 1'b0;
            pm_r   <= 2'h0;
            lit_r  <= 8'h00;
        end else if (clk_en) begin
            addr_r <= dif.faddr;
            bit_r  <= dif.bitsel;
            ps_r   <= dif.ptr_sel;
            pm_r   <= dif.ptr_mode;
            lit_r  <= dif.literal;
        end
    end

    assign fetch_req  = fetch_req_r;
    assign file_rd    = file_rd_r;
    assign file_wr    = file_wr_r;
    assign w_wr       = w_wr_r;
    assign file_addr  = addr_r;
    assign file_wdata = val_r;
    assign result     = val_r;
    assign flags      = flags_r;
    assign bit_sel    = bit_r;
    assign ptr_sel    = ps_r;
    assign ptr_mode   = pm_r;
    assign literal    = lit_r;
    assign cycle_end  = cyc_end_r;
    assign flushed    = flushed_r;
endmodule

// >>> bench/itd_core_asserts.sv
`timescale 1ns/1ns
module itd_core_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Observed outputs
    input wire logic fetch_req,
    input wire logic cycle_end,
    input wire logic file_rd,
    input wire logic file_wr,
    input wire logic w_wr,
    input wire logic flushed
);
    default clocking cb @(posedge clk); endclocking
    // A frozen core holds its pulses, so timing is only judged while enabled
    default disable iff (!nrst || !clk_en);

    AST_CYCLE_PERIOD:
        assert property (cycle_end |=> !cycle_end [*3] ##1 cycle_end) else $error("Cycle end not every four clocks");
    AST_FETCH_SPACING:
        assert property (fetch_req |=> !fetch_req [*3]) else $error("Fetches closer than four clocks");
    AST_FETCH_BOUND:
        assert property (fetch_req |-> ##[4:12] fetch_req) else $error("Instruction longer than three cycles");
    AST_FETCH_ALIGN:
        assert property (fetch_req |-> cycle_end) else $error("Fetch off a cycle boundary");
    AST_DEST_ONE:
        assert property (file_wr |-> !w_wr) else $error("Result sent to both destinations");
    AST_READ_TO_END:
        assert property (file_rd |-> ##3 cycle_end) else $error("File read not in second quarter");
    AST_WRITE_AFTER_READ:
        assert property (file_wr |-> $past(file_rd, 3)) else $error("File write without preceding read");
    AST_FLUSH_NO_READ:
        assert property (flushed |-> !file_rd) else $error("Discarded slot reads a file");
    AST_FLUSH_ONE_CYCLE:
        assert property ($rose(flushed) |-> flushed [*4] ##1 !flushed) else $error("Discarded slot not one cycle");
endmodule

bind itd_core itd_core_chk itd_core_chk_i (
    .clk(clk), .nrst(nrst), .clk_en(clk_en), .fetch_req(fetch_req), .cycle_end(cycle_end),
    .file_rd(file_rd), .file_wr(file_wr), .w_wr(w_wr), .flushed(flushed)
);

// >>> bench/itd_prog_mem.sv
`timescale 1ns/1ns
module itd_prog_mem (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  nrst,
    // Fetch side
    input  wire logic                  fetch_req,
    output logic [itd_pkg::WORD_W-1:0] insn_word
);
    // Filled by the bench; sequential only, branch targets are not followed
    logic [itd_pkg::WORD_W-1:0] mem [0:15];
    logic [3:0]                 ptr_r;
    logic [3:0]                 ptr_nxt;

    always_comb begin
        ptr_nxt = fetch_req ? ptr_r + 4'h1 : ptr_r;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ptr_r <= 4'h0;
        end else begin
            ptr_r <= ptr_nxt;
        end
    end

    assign insn_word = mem[ptr_r];
endmodule

// >>> bench/instruction_timing_decoder_tb.sv
`timescale 1ns/1ns
module instruction_timing_decoder_tb;
    // Control encodings of the decode map; plain defaults
    localparam logic [13:0] NOP_W  = 14'h0000;
    localparam logic [13:0] CALL_W = 14'h2000;
    localparam logic [13:0] JMP_W  = 14'h2800;
    localparam logic [13:0] RET_W  = 14'h0008;
    localparam logic [13:0] RETI_W = 14'h0009;
    localparam logic [13:0] CLW_W  = 14'h000A;
    localparam logic [13:0] BRW_W  = 14'h000B;
    localparam logic [13:0] RETK_W = 14'h3400;
    localparam logic [13:0] BRA_W  = 14'h3200;

    logic                          clk;
    logic                          nrst;
    logic                          clk_en;
    logic                          ptr_in_prog_mem;
    logic                          carry_in;
    logic                          skip_cond;
    logic [itd_pkg::WORD_W-1:0]    insn_word;
    logic [itd_pkg::DATA_W-1:0]    file_rdata;
    logic                          fetch_req;
    logic                          file_rd;
    logic                          file_wr;
    logic [itd_pkg::ADDR_W-1:0]    file_addr;
    logic [itd_pkg::DATA_W-1:0]    file_wdata;
    logic                          w_wr;
    logic [itd_pkg::DATA_W-1:0]    result;
    logic [2:0]                    flags;
    logic [itd_pkg::BIT_W-1:0]     bit_sel;
    logic                          ptr_sel;
    logic [itd_pkg::MODE_W-1:0]    ptr_mode;
    logic [itd_pkg::LIT_W-1:0]     literal;
    logic                          cycle_end;
    logic                          flushed;
    int                            n_fail;
    int                            checked;
    logic                          rd_seen;
    logic                          fl_seen;
    logic [itd_pkg::WORD_W-1:0]    prog [$];

    itd_core itd_core_i (
        .clk(clk), .nrst(nrst), .clk_en(clk_en), .insn_word(insn_word), .file_rdata(file_rdata),
        .ptr_in_prog_mem(ptr_in_prog_mem), .carry_in(carry_in), .skip_cond(skip_cond),
        .fetch_req(fetch_req), .file_rd(file_rd), .file_wr(file_wr), .file_addr(file_addr),
        .file_wdata(file_wdata), .w_wr(w_wr), .result(result), .flags(flags), .bit_sel(bit_sel),
        .ptr_sel(ptr_sel), .ptr_mode(ptr_mode), .literal(literal), .cycle_end(cycle_end), .flushed(flushed)
    );

    itd_prog_mem itd_prog_mem_i (.clk(clk), .nrst(nrst), .fetch_req(fetch_req), .insn_word(insn_word));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Memory is loaded while reset holds the fetch pointer at zero
    task automatic start(input logic [7:0] rd, input logic pm, input logic cin);
        @(posedge clk);
        #1;
        nrst = 1'b0;
        file_rdata = rd;
        ptr_in_prog_mem = pm;
        carry_in = cin;
        for (int i = 0; i < 16; i++) begin
            itd_prog_mem_i.mem[i] = (i < prog.size()) ? prog[i] : NOP_W;
        end
        repeat (5) @(posedge clk);
        #1;
        nrst = 1'b1;
    endtask

    task automatic step(output int gap);
        gap = 0;
        rd_seen = 1'b0;
        do begin
            @(posedge clk);
            #1;
            gap++;
            if (file_rd === 1'b1) rd_seen = 1'b1;
            if (flushed === 1'b1) fl_seen = 1'b1;
        end while (fetch_req !== 1'b1 && gap < 16);
        check(32'(gap < 16), 32'h0000_0001);
    endtask

    task automatic t_timing();
        int g;
        int exp [10] = '{4, 8, 8, 8, 8, 8, 8, 8, 8, 4};
        prog = '{14'h08FF, CALL_W, RET_W, RETK_W, RETI_W, CLW_W, JMP_W, BRA_W, BRW_W, 14'h31FF, NOP_W};
        start(8'h00, 1'b0, 1'b0);
        step(g);
        foreach (exp[i]) begin
            step(g);
            check(32'(g), 32'(exp[i]));
        end
        $display("test timing done");
    endtask

    task automatic t_rmw();
        int g;
        prog = '{14'h08FF, 14'h087F, 14'h0080, NOP_W};
        start(8'hA5, 1'b0, 1'b0);
        step(g);
        step(g);
        check(32'({file_wr, w_wr, rd_seen, file_addr, file_wdata}), 32'({3'b101, 7'h7F, 8'hA5}));
        step(g);
        check(32'({file_wr, w_wr, result}), 32'({2'b01, 8'hA5}));
        step(g);
        check(32'({file_wr, rd_seen, file_addr, file_wdata}), 32'({2'b11, 7'h00, 8'hA5}));
        $display("test read modify write done");
    endtask

    task automatic t_bits();
        int g;
        prog = '{14'h1705, 14'h305A, 14'h0103, 14'h305A, 14'h0100, NOP_W};
        start(8'h00, 1'b0, 1'b0);
        step(g);
        step(g);
        check(32'({file_wr, bit_sel, file_wdata}), 32'({1'b1, 3'h6, 8'h40}));
        for (int k = 0; k < 2; k++) begin
            step(g);
            check(32'({w_wr, literal, result}), 32'({1'b1, 8'h5A, 8'h5A}));
            step(g);
            check(32'({w_wr, result}), 32'({1'b1, 8'h00}));
        end
        $display("test fields done");
    endtask

    task automatic t_arith();
        int g;
        prog = '{14'h30FF, 14'h3D05, 14'h3B05, NOP_W};
        start(8'h01, 1'b0, 1'b1);
        step(g);
        step(g);
        step(g);
        check(32'({w_wr, result, flags}), 32'({1'b1, 8'h01, 3'b110}));
        step(g);
        check(32'({w_wr, result, flags}), 32'({1'b1, 8'h00, 3'b111}));
        $display("test arithmetic done");
    endtask

    task automatic t_skip();
        logic [13:0] sw [6] = '{14'h0B85, 14'h0B85, 14'h0F85, 14'h1C05, 14'h1C05, 14'h1805};
        logic [7:0]  sr [6] = '{8'h01, 8'h02, 8'hFF, 8'h01, 8'h00, 8'h00};
        logic        st [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
        logic        saw;
        logic [7:0]  last;
        foreach (sw[k]) begin
            prog = '{sw[k], 14'h3033, 14'h3044, NOP_W};
            start(sr[k], 1'b0, 1'b0);
            saw = 1'b0;
            fl_seen = 1'b0;
            last = 8'h00;
            repeat (28) begin
                @(posedge clk);
                #1;
                if (w_wr === 1'b1 && result === 8'h33) saw = 1'b1;
                if (w_wr === 1'b1) last = result;
                if (flushed === 1'b1) fl_seen = 1'b1;
            end
            check(32'({saw, fl_seen, last}), 32'({!st[k], st[k], 8'h44}));
        end
        $display("test skips done");
    endtask

    task automatic t_indirect();
        int g;
        for (int pm = 0; pm < 2; pm++) begin
            for (int k = 0; k < 8; k++) begin
                prog = '{14'h0010 | 14'(k), NOP_W};
                start(8'h00, pm[0], 1'b0);
                step(g);
                step(g);
                check(32'({g[7:0], ptr_sel, ptr_mode}), 32'({8'(4 + 4 * pm), k[2:0]}));
            end
        end
        $display("test indirect done");
    endtask

    // Six frozen clocks in the second quarter stretch the cycle by six
    task automatic t_freeze();
        int g;
        prog = '{14'h30C3, NOP_W};
        start(8'h00, 1'b0, 1'b0);
        step(g);
        @(posedge clk);
        #1;
        clk_en = 1'b0;
        repeat (6) @(posedge clk);
        #1;
        clk_en = 1'b1;
        step(g);
        check(32'({g[7:0], w_wr, result}), 32'({8'h03, 1'b1, 8'hC3}));
        $display("test clock enable done");
    endtask

    initial begin
        n_fail = 0;
        checked = 0;
        nrst = 1'b0;
        clk_en = 1'b1;
        skip_cond = 1'b0;
        carry_in = 1'b0;
        ptr_in_prog_mem = 1'b0;
        file_rdata = 8'h00;
        rd_seen = 1'b0;
        fl_seen = 1'b0;
        t_timing();
        t_rmw();
        t_bits();
        t_arith();
        t_skip();
        t_indirect();
        t_freeze();
        end_of_test();
    end

    // Whole run needs under 1500 clocks
    initial begin
        #50000;
        n_fail++;
        $display("watchdog expired at %0t", $time);
        end_of_test();
    end
endmodule
